// *** rtl/sac_pkg.sv ***
// How it works
// - SAR conversion at 12, 10, 8 or 6 bits, chosen by software
// - channel selector covers 19 inputs: 16 pins, temperature, reference, half battery
// - results sit in 16-bit registers, left or right aligned
// - calibrate_start starts calibration, reads one while busy, hardware clears it
// - calibration factor kept and applied until converter powers off
// - calibration_reset_request clears the stored calibration factor
// - converter logic runs on the bus clock, stepped by a converter-rate enable pulse
// - converter_on low holds the converter in reset and powered down
// - regular group: three sequence registers, 4-bit length, up to 16
// - inserted group: one sequence register, 2-bit length, up to 4
// - single mode: one conversion per trigger, first regular or last inserted slot
// - regular done stores result, sets done flag, interrupts if enabled
// - inserted done stores result zero, sets both flags, interrupts if enabled
// - writing zero to a done flag clears it
// - start by software bit or selected hardware trigger with polarity
// - oversampler: ratio 2 to 256, right shift up to 15, 16-bit result
// - DMA request raised when a regular result is available
// - interrupts on regular done, inserted done and watchdog range events
package sac_pkg;
  localparam int unsigned SYS_HZ   = 50_000_000;
  localparam int unsigned CONV_HZ  = 12_500_000;       // converter clock rate
  localparam int unsigned CONV_DIV = SYS_HZ / CONV_HZ; // must stay at two or more
  localparam int unsigned AW       = 8;
  localparam logic [AW-1:0] A_STAT  = 8'h00, A_CTL0 = 8'h04, A_CTL1 = 8'h08,
                            A_SAMPT = 8'h0c, A_WDHI = 8'h10, A_WDLO = 8'h14,
                            A_RSEQ0 = 8'h18, A_RSEQ1 = 8'h1c, A_RSEQ2 = 8'h20,
                            A_ISEQ  = 8'h24, A_IRES0 = 8'h28, A_RRES = 8'h2c,
                            A_OVS   = 8'h30;
  // status flags
  localparam int F_WD = 0, F_DONE = 1, F_INS = 2;
  // control 0
  localparam int B_DONE_IE = 5, B_WD_IE = 6, B_INS_IE = 7;
  localparam logic [31:0] CTL0_MASK = 32'h0000_19e0;
  // control 1
  localparam int B_ON = 0, B_CAL = 2, B_CALRST = 3, B_DMA = 8, B_ALIGN = 11;
  localparam int ISEL_LO = 12, B_IEN = 15, RSEL_LO = 17, B_REN = 20;
  localparam int B_ISW = 21, B_RSW = 22, IPOL_LO = 24, RPOL_LO = 26;
  localparam logic [31:0] CTL1_MASK = 32'h0f1e_f903;
  // sequences
  localparam int SLOT_W = 5, RLEN_LO = 20, ILEN_LO = 20, ILAST_LO = 15;
  localparam logic [31:0] RSEQ0_MASK = 32'h00ff_ffff, RSEQ_MASK = 32'h3fff_ffff;
  localparam logic [31:0] ISEQ_MASK  = 32'h003f_ffff;
  // oversampler and resolution
  localparam int B_OVS_EN = 0, RATIO_LO = 2, SHIFT_LO = 5, RES_LO = 12;
  localparam logic [31:0] OVS_MASK = 32'h0000_31fd;
  localparam logic [11:0] WDHI_RST = 12'hfff;
  localparam logic [4:0]  CHAN_MAX = 5'h12;
  localparam logic [1:0]  G_REG = 2'h0, G_INS = 2'h1, G_CAL = 2'h2;
  typedef enum logic [1:0] {S_IDLE, S_SAMPLE, S_CONV, S_STORE} sac_state_t;
endpackage

// *** rtl/sac_top.sv ***
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ps
module sac_top (
  input  wire logic                      sys_clk_i,
  input  wire logic                      nrst_i,
  input  wire logic                      psel_i,
  input  wire logic                      penable_i,
  input  wire logic                      pwrite_i,
  input  wire logic [sac_pkg::AW-1:0]    paddr_i,
  input  wire logic [31:0]               pwdata_i,
  output logic      [31:0]               prdata_o,
  output logic                           pready_o,
  output logic                           pslverr_o,
  input  wire logic [7:0]                trig_i,
  input  wire logic                      sar_cmp_i,
  output logic      [4:0]                chan_sel_o,
  output logic                           sample_o,
  output logic      [11:0]               dac_code_o,
  output logic                           cal_mode_o,
  output logic                           power_down_o,
  output logic                           dma_req_o,
  output logic                           irq_o
);
  import sac_pkg::*;

  function automatic logic trig_hit(input logic [7:0] s, input logic [7:0] d,
                                    input logic [2:0] sel, input logic [1:0] pol);
    logic r;
    logic f;
    r = s[sel] & ~d[sel];
    f = ~s[sel] & d[sel];
    trig_hit = (pol[0] & r) | (pol[1] & f); // bit 0 rising, bit 1 falling
  endfunction

  // out-of-range slot codes fall back to input zero
  function automatic logic [4:0] chan_fix(input logic [4:0] c);
    chan_fix = (c > CHAN_MAX) ? 5'h00 : c;
  endfunction

  logic [31:0] ctl0, ctl1, rseq0, rseq1, rseq2, iseq, ovs;
  logic [7:0]  sampt;
  logic [11:0] wdhi, wdlo, cal_factor;
  logic [15:0] reg_res, ins_res0;
  logic        flag_wd, flag_done, flag_ins, cal_busy, ins_pend, reg_pend;
  logic [7:0]  trig_m, trig_s, trig_d;
  logic        cmp_m, cmp_s;
  logic [31:0] rd_val;
  logic        rd_ok;
  logic        wr, rd_acc, setup;
  logic        conv_on, tick, idle_tick, take_cal, take_ins, take_reg, cal_rst_p, cal_fin;
  logic [$clog2(CONV_DIV)-1:0] div_cnt;
  sac_state_t  st;
  logic [7:0]  scnt, ocnt;
  logic [11:0] code, corr, v;
  logic [3:0]  bidx, lsb_q;
  logic [1:0]  grp, done_grp;
  logic [19:0] acc, acc_n;
  logic        done_p, wd_q, ovs_last;
  logic [15:0] fin, ovs_val, algn;

  assign wr        = psel_i & penable_i & pwrite_i;
  assign rd_acc    = psel_i & penable_i & ~pwrite_i;
  assign setup     = psel_i & ~penable_i;
  assign pready_o  = 1'b1;                       // no wait states
  assign dac_code_o = code;                      // trial code comes straight from its flops
  assign conv_on   = ctl1[B_ON];
  assign cal_rst_p = wr & (paddr_i == A_CTL1) & pwdata_i[B_CALRST];
  assign cal_fin   = done_p & (done_grp == G_CAL);

  // two flops on every pin input; a third stage only for edge detect
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      trig_m <= 8'h00;
      trig_s <= 8'h00;
      trig_d <= 8'h00;
      cmp_m  <= 1'b0;
      cmp_s  <= 1'b0;
    end else begin
      trig_m <= trig_i;
      trig_s <= trig_m;
      trig_d <= trig_s;
      cmp_m  <= sar_cmp_i;
      cmp_s  <= cmp_m;
    end
  end

  // converter clock as an enable pulse from the bus clock
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_cnt <= '0;
    end else if (div_cnt == ($clog2(CONV_DIV))'(CONV_DIV - 1)) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end
  assign tick = (div_cnt == ($clog2(CONV_DIV))'(CONV_DIV - 1));

  // software-written configuration
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctl0  <= 32'h0000_0000;
      ctl1  <= 32'h0000_0000;
      rseq0 <= 32'h0000_0000;
      rseq1 <= 32'h0000_0000;
      rseq2 <= 32'h0000_0000;
      iseq  <= 32'h0000_0000;
      ovs   <= 32'h0000_0000;
      sampt <= 8'h00;
      wdhi  <= WDHI_RST;
      wdlo  <= 12'h000;
    end else if (wr) begin
      case (paddr_i)
        A_CTL0:  ctl0  <= pwdata_i & CTL0_MASK;
        A_CTL1:  ctl1  <= pwdata_i & CTL1_MASK;
        A_RSEQ0: rseq0 <= pwdata_i & RSEQ0_MASK;   // length field here
        A_RSEQ1: rseq1 <= pwdata_i & RSEQ_MASK;
        A_RSEQ2: rseq2 <= pwdata_i & RSEQ_MASK;
        A_ISEQ:  iseq  <= pwdata_i & ISEQ_MASK;    // four slots and length
        A_OVS:   ovs   <= pwdata_i & OVS_MASK;
        A_SAMPT: sampt <= pwdata_i[7:0];
        A_WDHI:  wdhi  <= pwdata_i[11:0];
        A_WDLO:  wdlo  <= pwdata_i[11:0];
        default: ;
      endcase
    end
  end

  // calibration busy bit: software sets, hardware clears on finish
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cal_busy <= 1'b0;
    end else if (!conv_on || cal_fin) begin
      cal_busy <= 1'b0;
    end else if (wr && paddr_i == A_CTL1 && pwdata_i[B_CAL]) begin
      cal_busy <= 1'b1;
    end
  end

  // factor lives until power-off or an explicit reset
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cal_factor <= 12'h000;
    end else if (!conv_on || cal_rst_p) begin
      cal_factor <= 12'h000;
    end else if (cal_fin) begin
      cal_factor <= fin[11:0];
    end
  end

  // start requests: a new request in the take cycle stays pending
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ins_pend <= 1'b0;
      reg_pend <= 1'b0;
    end else if (!conv_on) begin
      ins_pend <= 1'b0;
      reg_pend <= 1'b0;
    end else begin
      ins_pend <= (ins_pend & ~take_ins)
                | (wr && paddr_i == A_CTL1 && pwdata_i[B_ISW])
                | (ctl1[B_IEN] & trig_hit(trig_s, trig_d, ctl1[ISEL_LO +: 3],
                                          ctl1[IPOL_LO +: 2]));
      reg_pend <= (reg_pend & ~take_reg)
                | (wr && paddr_i == A_CTL1 && pwdata_i[B_RSW])
                | (ctl1[B_REN] & trig_hit(trig_s, trig_d, ctl1[RSEL_LO +: 3],
                                          ctl1[RPOL_LO +: 2]));
    end
  end

  // calibration first, then inserted, then regular; nothing starts while calibrating
  assign idle_tick = tick & conv_on & (st == S_IDLE);
  assign take_cal  = idle_tick & cal_busy;
  assign take_ins  = idle_tick & ~cal_busy & ins_pend;
  assign take_reg  = idle_tick & ~cal_busy & ~ins_pend & reg_pend;

  // corrected sample, reduced to the chosen resolution
  assign corr     = (code >= cal_factor) ? code - cal_factor : 12'h000;
  assign v        = (grp == G_CAL) ? code : (corr >> lsb_q);
  assign acc_n    = acc + {8'h00, v};
  assign ovs_last = (ocnt == 8'((9'h002 << ovs[RATIO_LO +: 3]) - 9'h001));
  assign ovs_val  = 16'(acc_n >> ovs[SHIFT_LO +: 4]);
  assign algn     = ctl1[B_ALIGN] ? ({4'h0, v} << (5'h04 + {1'b0, lsb_q}))
                                  : {4'h0, v};

  // sample and successive approximation, one step per converter tick
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st         <= S_IDLE;
      scnt       <= 8'h00;
      code       <= 12'h000;
      bidx       <= 4'h0;
      lsb_q      <= 4'h0;
      grp        <= G_REG;
      acc        <= 20'h00000;
      ocnt       <= 8'h00;
      sample_o   <= 1'b0;
      chan_sel_o <= 5'h00;
      cal_mode_o <= 1'b0;
      done_p     <= 1'b0;
      done_grp   <= G_REG;
      fin        <= 16'h0000;
      wd_q       <= 1'b0;
    end else if (!conv_on) begin                 // held in reset
      st         <= S_IDLE;
      sample_o   <= 1'b0;
      cal_mode_o <= 1'b0;
      acc        <= 20'h00000;
      ocnt       <= 8'h00;
      done_p     <= 1'b0;
    end else begin
      done_p <= 1'b0;
      if (tick) begin
        case (st)
          S_IDLE: begin
            if (take_cal || take_ins || take_reg) begin    // one per trigger
              grp        <= take_cal ? G_CAL : (take_ins ? G_INS : G_REG);
              lsb_q      <= take_cal ? 4'h0 : {1'b0, ovs[RES_LO +: 2], 1'b0};
              chan_sel_o <= take_ins ? chan_fix(iseq[ILAST_LO +: SLOT_W])
                                     : chan_fix(rseq2[SLOT_W-1:0]);
              cal_mode_o <= take_cal;
              sample_o   <= 1'b1;
              scnt       <= sampt;
              st         <= S_SAMPLE;
            end
          end
          S_SAMPLE: begin
            if (scnt == 8'h00) begin
              sample_o <= 1'b0;
              code     <= 12'h800;
              bidx     <= 4'hb;
              st       <= S_CONV;
            end else begin
              scnt <= scnt - 8'h01;
            end
          end
          S_CONV: begin
            code[bidx] <= cmp_s;                 // keep the bit if input is above
            if (bidx == lsb_q) begin
              st <= S_STORE;
            end else begin
              code[bidx - 4'h1] <= 1'b1;
              bidx              <= bidx - 4'h1;
            end
          end
          S_STORE: begin
            if (ovs[B_OVS_EN] && grp != G_CAL && !ovs_last) begin
              acc      <= acc_n;
              ocnt     <= ocnt + 8'h01;
              sample_o <= 1'b1;
              scnt     <= sampt;
              st       <= S_SAMPLE;
            end else begin
              done_p     <= 1'b1;
              done_grp   <= grp;
              fin        <= (grp == G_CAL) ? {4'h0, code}
                          : (ovs[B_OVS_EN] ? ovs_val : algn);
              wd_q       <= (grp != G_CAL) && ((v > wdhi) || (v < wdlo));
              acc        <= 20'h00000;
              ocnt       <= 8'h00;
              cal_mode_o <= 1'b0;
              st         <= S_IDLE;
            end
          end
          default: st <= S_IDLE;
        endcase
      end
    end
  end

  // result registers
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_res  <= 16'h0000;
      ins_res0 <= 16'h0000;
    end else if (done_p && done_grp == G_REG) begin
      reg_res <= fin;
    end else if (done_p && done_grp == G_INS) begin
      ins_res0 <= fin;
    end
  end

  // status flags: hardware set beats a software write of zero
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flag_wd   <= 1'b0;
      flag_done <= 1'b0;
      flag_ins  <= 1'b0;
    end else begin
      flag_wd   <= (flag_wd & ~(wr && paddr_i == A_STAT && !pwdata_i[F_WD]))
                 | (done_p & wd_q);
      flag_done <= (flag_done & ~(wr && paddr_i == A_STAT && !pwdata_i[F_DONE]))
                 | (done_p & (done_grp != G_CAL));
      flag_ins  <= (flag_ins & ~(wr && paddr_i == A_STAT && !pwdata_i[F_INS]))
                 | (done_p & (done_grp == G_INS));
    end
  end

  // dma request held until the regular result is read; new result wins
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dma_req_o <= 1'b0;
    end else begin
      dma_req_o <= (dma_req_o & ~(rd_acc && paddr_i == A_RRES))
                 | (done_p & (done_grp == G_REG) & ctl1[B_DMA]);
    end
  end

  // interrupt line and power-down pin
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_o        <= 1'b0;
      power_down_o <= 1'b1;
    end else begin
      irq_o        <= (flag_done & ctl0[B_DONE_IE]) | (flag_ins & ctl0[B_INS_IE])
                    | (flag_wd & ctl0[B_WD_IE]);
      power_down_o <= ~conv_on;
    end
  end

  // read decode; live bits are merged into control 1
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok  = 1'b1;
    case (paddr_i)
      A_STAT: begin
        rd_val[F_WD]   = flag_wd;
        rd_val[F_DONE] = flag_done;
        rd_val[F_INS]  = flag_ins;
      end
      A_CTL0: rd_val = ctl0;
      A_CTL1: begin
        rd_val        = ctl1;
        rd_val[B_CAL] = cal_busy;
        rd_val[B_ISW] = ins_pend;
        rd_val[B_RSW] = reg_pend;
      end
      A_SAMPT: rd_val = {24'h000000, sampt};
      A_WDHI:  rd_val = {20'h00000, wdhi};
      A_WDLO:  rd_val = {20'h00000, wdlo};
      A_RSEQ0: rd_val = rseq0;
      A_RSEQ1: rd_val = rseq1;
      A_RSEQ2: rd_val = rseq2;
      A_ISEQ:  rd_val = iseq;
      A_IRES0: rd_val = {16'h0000, ins_res0};
      A_RRES:  rd_val = {16'h0000, reg_res};
      A_OVS:   rd_val = ovs;
      default: rd_ok = 1'b0;
    endcase
  end

  // read data and error captured in the setup cycle so they come from flops
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else if (setup) begin
      prdata_o  <= pwrite_i ? 32'h0000_0000 : rd_val;
      pslverr_o <= ~rd_ok;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_reg_done;
    done_p && done_grp == G_REG;
  endsequence
  sequence s_ins_done;
    done_p && done_grp == G_INS;
  endsequence

  cal_start_a: assert property (wr && paddr_i == A_CTL1 && pwdata_i[B_CAL]
      && pwdata_i[B_ON] && conv_on && !cal_fin |=> cal_busy ##1 (cal_busy || $past(cal_fin)))
    else $error("calibration start not seen");
  off_reset_a: assert property (!conv_on |=> st == S_IDLE && !sample_o
      && cal_factor == 12'h000 && power_down_o)
    else $error("converter not held off");
  cal_reset_a: assert property (cal_rst_p |=> cal_factor == 12'h000)
    else $error("calibration reset ignored");
  reg_done_a: assert property (s_reg_done |=> flag_done && reg_res == $past(fin))
    else $error("regular result not stored");
  ins_done_a: assert property (s_ins_done |=> flag_done && flag_ins && ins_res0 == $past(fin))
    else $error("inserted result not stored");
  flag_clear_a: assert property (wr && paddr_i == A_STAT && !pwdata_i[F_DONE] && !done_p
      |=> !flag_done)
    else $error("done flag not cleared");
  take_start_a: assert property (take_reg |=> sample_o && st == S_SAMPLE
      && chan_sel_o == chan_fix($past(rseq2[SLOT_W-1:0])))
    else $error("regular start wrong");
  dma_req_a: assert property ((s_reg_done and ctl1[B_DMA]) |=> dma_req_o)
    else $error("dma request missing");
  irq_out_a: assert property (flag_done && ctl0[B_DONE_IE] |=> irq_o)
    else $error("interrupt missing");
endmodule

// *** tb/sac_analog_model.sv ***
`timescale 1ns/1ps
// far side of the block: the analog inputs behind the selector and the comparator
module sac_analog_model (
  input  wire logic        sys_clk_i,
  input  wire logic [4:0]  chan_sel_i,
  input  wire logic [11:0] dac_code_i,
  input  wire logic        cal_mode_i,
  input  wire logic        power_down_i,
  output logic             sar_cmp_o
);
  logic [11:0] level [0:18];
  logic [11:0] offset;
  logic [11:0] held;

  initial begin
    sar_cmp_o = 1'b0;
    offset    = 12'h000;
    foreach (level[k]) level[k] = 12'h000;
  end

  // the held voltage follows the selected input, or the offset during calibration
  always @(posedge sys_clk_i) begin
    held <= cal_mode_i ? offset : level[chan_sel_i];
  end

  // a powered-down comparator gives no valid answer, so it toggles instead
  always @(posedge sys_clk_i) begin
    // an unknown power-down level before reset counts as powered down
    sar_cmp_o <= (power_down_i !== 1'b0) ? ~sar_cmp_o : (held >= dac_code_i);
  end
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
module testbench;
  import sac_pkg::*;
  localparam int CAL_OFS = 5;
  logic        sys_clk = 1'b0;
  logic        nrst_i  = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [7:0]  trig_i  = 8'h00;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic        sar_cmp;
  logic [4:0]  chan_sel_o;
  logic        sample_o;
  logic [11:0] dac_code_o;
  logic        cal_mode_o;
  logic        power_down_o;
  logic        dma_req_o;
  logic        irq_o;
  int          mismatches = 0;
  int          n_compared = 0;
  int          seed = 84;
  int          wd_hi = 12'hfff;
  int          wd_lo = 0;
  int          ovs_ratio = -1;                   // below zero: oversampler off
  int          ovs_shift = 0;

  sac_top i_sac_top (
    .sys_clk_i(sys_clk), .nrst_i(nrst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .trig_i(trig_i), .sar_cmp_i(sar_cmp),
    .chan_sel_o(chan_sel_o), .sample_o(sample_o), .dac_code_o(dac_code_o),
    .cal_mode_o(cal_mode_o), .power_down_o(power_down_o), .dma_req_o(dma_req_o),
    .irq_o(irq_o));

  sac_analog_model i_sac_analog_model (
    .sys_clk_i(sys_clk), .chan_sel_i(chan_sel_o), .dac_code_i(dac_code_o),
    .cal_mode_i(cal_mode_o), .power_down_i(power_down_o), .sar_cmp_o(sar_cmp));

  // 50 MHz system clock
  always #10 sys_clk = ~sys_clk;

  task print_verdict();
    if (mismatches == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // one apb transfer: setup, then access held until pready is seen high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    @(posedge sys_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready_o !== 1'b1) @(posedge sys_clk);
    r = prdata_o;
    e = pslverr_o;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask

  // settle time after switching on: 14 converter clocks
  task power_up();
    wr(A_CTL1, 32'h1);
    repeat (14 * CONV_DIV) @(posedge sys_clk);
    `CHK(power_down_o, 1'b0)
  endtask

  task calib();
    logic [31:0] r;
    int          i;
    wr(A_CTL1, 32'h1 | (32'h1 << B_CAL)); // no conversion is asked for meanwhile
    rd(A_CTL1, r);
    `CHK(r[B_CAL], 1'b1)
    repeat (4) @(posedge sys_clk);
    `CHK(cal_mode_o, 1'b1)
    i = 0;
    while (r[B_CAL] !== 1'b0 && i < 100) begin
      rd(A_CTL1, r);
      i++;
    end
    `CHK(r[B_CAL], 1'b0)
    `CHK(cal_mode_o, 1'b0)
  endtask

  // one single conversion on a random channel, checked against the reference model
  task automatic conv(input bit ins, input int res, input bit left, input int trg,
                      input int cal);
    logic [31:0] r;
    logic [31:0] c1;
    logic [15:0] ex;
    int          ch;
    int          lv;
    int          v;
    int          i;
    ch = $unsigned($random(seed)) % 19;
    lv = $random(seed) & 32'hfff;
    i_sac_analog_model.level[ch] = lv[11:0];
    v = (lv > cal) ? (lv - cal) >> (2 * res) : 0;
    ex = left ? 16'(v << (4 + 2 * res)) : 16'(v);
    // oversampling: 2^(ratio+1) equal samples summed, then shifted right
    if (ovs_ratio >= 0) ex = 16'((v << (ovs_ratio + 1)) >> ovs_shift);
    wr(A_OVS, (32'(res) << RES_LO) | ((ovs_ratio < 0) ? 32'h0 : ((32'h1 << B_OVS_EN) |
       (32'(ovs_ratio) << RATIO_LO) | (32'(ovs_shift) << SHIFT_LO))));
    wr(ins ? A_ISEQ : A_RSEQ2, ins ? 32'(ch) << ILAST_LO : 32'(ch));
    c1 = 32'h1 | (32'h1 << B_DMA) | (32'(left) << B_ALIGN);
    if (trg < 0) c1 |= 32'h1 << (ins ? B_ISW : B_RSW);
    else if (ins) c1 |= (32'h1 << B_IEN) | (32'(trg) << ISEL_LO) | (32'h1 << IPOL_LO);
    else c1 |= (32'h1 << B_REN) | (32'(trg) << RSEL_LO) | (32'h1 << RPOL_LO);
    wr(A_CTL1, c1); // scan and repeat modes stay off
    if (trg >= 0) begin
      trig_i <= 8'h01 << trg;
      repeat (8) @(posedge sys_clk);
      trig_i <= 8'h00;
    end
    i = 0;
    do begin
      rd(A_STAT, r);
      i++;
    end while (r[F_DONE] !== 1'b1 && i < 200);
    `CHK(r[F_DONE], 1'b1)
    `CHK(sample_o, 1'b0)
    `CHK(r[F_INS], logic'(ins))
    `CHK(r[F_WD], logic'(lv > wd_hi || lv < wd_lo))
    `CHK(irq_o, 1'b1)
    `CHK(dma_req_o, logic'(!ins))
    rd(ins ? A_IRES0 : A_RRES, r);
    `CHK(r[15:0], ex)
    wr(A_STAT, 32'h0);
    `CHK(dma_req_o, 1'b0)
    // long enough for a second conversion to show if one were started with the oversampler off
    repeat (80) @(posedge sys_clk);
    rd(A_STAT, r);
    `CHK(r[2:0], 3'h0)
    `CHK(irq_o, 1'b0)
  endtask

  // cuts a hang short well beyond the expected run length
  initial begin
    repeat (60000) @(posedge sys_clk);
    mismatches++;
    print_verdict();
  end

  initial begin
    logic [31:0] r;
    logic        e;
    int          k;
    repeat (2) @(posedge sys_clk);
    nrst_i <= 1'b1;
    `CHK(power_down_o, 1'b1)
    rd(A_WDHI, r);
    `CHK(r[11:0], WDHI_RST)
    apb(1'b0, 8'h40, 32'h0, r, e);
    `CHK(e, 1'b1)
    i_sac_analog_model.offset = 12'(CAL_OFS);
    wr(A_CTL1, 32'h1 << B_RSW);
    repeat (100) @(posedge sys_clk);
    rd(A_STAT, r);
    `CHK(r[F_DONE], 1'b0)
    wr(A_CTL0, 32'h1 << B_DONE_IE);
    power_up();
    for (k = 0; k < 16; k++) conv(1'b0, k % 4, 1'b0, -1, 0);
    conv(1'b0, 0, 1'b1, -1, 0);
    for (k = 0; k < 4; k++) conv(1'b1, 0, 1'b0, -1, 0);
    // every trigger select, alternating the two groups
    for (k = 0; k < 8; k++) conv(k[0], 0, 1'b0, k, 0);
    ovs_ratio = 1;
    ovs_shift = 1;
    conv(1'b0, 0, 1'b0, -1, 0);
    conv(1'b1, 0, 1'b0, -1, 0);
    ovs_ratio = -1;
    calib();
    conv(1'b0, 0, 1'b0, -1, CAL_OFS);
    conv(1'b1, 0, 1'b0, -1, CAL_OFS);
    wr(A_CTL1, 32'h1 | (32'h1 << B_CALRST));
    conv(1'b0, 0, 1'b0, -1, 0);
    calib(); // recalibration with the offset unchanged
    wr(A_CTL1, 32'h0);
    power_up();
    conv(1'b0, 0, 1'b0, -1, 0);
    wd_hi = 12'h010;
    wr(A_CTL0, (32'h1 << B_DONE_IE) | (32'h1 << B_WD_IE));
    wr(A_WDHI, 32'(wd_hi));
    for (k = 0; k < 3; k++) conv(1'b0, 0, 1'b0, -1, 0);
    print_verdict();
  end
endmodule
